// file: dlm_regs_top.sv
`timescale 1ns/1ps
// Overview of operation
// - error counter or receiver lock loss drops link lock
// - counter advances on pixel clock periods only
// - parity, clock and control faults count
// - lock lost when count reaches threshold
// - bit 4 enables error counting
// - counting disabled: first error drops lock
// - ignore bit set: filter-wait errors ignored
// - ignore bit clear: filter-wait errors count
// - encoder bit 7 set disables crc check
// - crc on: failed packets never update info
// - raw frame start after minimum valid time
// - pulldown on when input, unless disabled
// - port select picks per-port register target
module dlm_regs_top
#(
    parameter int NPORTS = 2,
    parameter int NGPIO  = 7
)
(
    input  wire logic                   sys_clk,
    input  wire logic                   rst,
    // register access from the i2c target
    input  wire logic [7:0]             reg_addr,
    input  wire logic [7:0]             reg_wdata,
    input  wire logic                   reg_wr,
    input  wire logic                   reg_rd,
    output logic [7:0]                  reg_rdata,
    output logic                        reg_rvalid,
    // per-port link side
    input  wire logic [NPORTS-1:0]      pix_en,
    input  wire logic [NPORTS-1:0]      cdr_lock,
    input  wire logic [NPORTS-1:0]      err_parity,
    input  wire logic [NPORTS-1:0]      err_clock,
    input  wire logic [NPORTS-1:0]      err_ctrl,
    input  wire logic [NPORTS-1:0]      filter_wait,
    input  wire logic [NPORTS-1:0]      raw_mode,
    input  wire logic [NPORTS-1:0]      frame_valid,
    input  wire logic [NPORTS-1:0]      enc_pkt_valid,
    input  wire logic [NPORTS-1:0]      enc_pkt_crc_ok,
    input  wire logic [NPORTS-1:0][7:0] enc_pkt_info,
    output logic [NPORTS-1:0]           link_locked,
    output logic [NPORTS-1:0]           frame_start,
    output logic [NPORTS-1:0][7:0]      link_info,
    // gpio pads
    input  wire logic [NGPIO-1:0]       gpio_out_en,
    output logic [NGPIO-1:0]            gpio_pulldown_en
);

    logic [7:0]             port_sel;
    logic                   crc_cap;
    logic [NGPIO-1:0]       pd_dis;

    logic [NPORTS-1:0][3:0] thresh;
    logic [NPORTS-1:0]      cnt_en;
    logic [NPORTS-1:0]      wait_ign;
    logic [NPORTS-1:0]      crc_dis;
    logic [NPORTS-1:0][6:0] enc_rsvd;
    logic [NPORTS-1:0][7:0] fv_min;

    logic [NPORTS-1:0]      mon_locked;
    logic [NPORTS-1:0][3:0] mon_count;
    logic [NPORTS-1:0]      fs_pulse;

    logic                   rd_port;
    logic [7:0]             next_rdata;

    // shared registers
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            port_sel <= dlm_pkg::RST_PORT_SEL;
            crc_cap  <= dlm_pkg::RST_CRC_CAP;
            pd_dis   <= dlm_pkg::RST_PD_DIS;
        end
        else if (reg_wr)
        begin
            if (reg_addr == dlm_pkg::OFS_PORT_SEL)
            begin
                port_sel <= reg_wdata;
            end
            if (reg_addr == dlm_pkg::OFS_ENC_CAP)
            begin
                crc_cap <= reg_wdata[dlm_pkg::CAP_BIT];
            end
            if (reg_addr == dlm_pkg::OFS_GPIO_PD_DIS)
            begin
                pd_dis <= reg_wdata[NGPIO-1:0];
            end
        end
    end

    // pulldown only while the pin is not driven
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            gpio_pulldown_en <= ~gpio_out_en & ~dlm_pkg::RST_PD_DIS;
        end
        else
        begin
            gpio_pulldown_en <= ~gpio_out_en & ~pd_dis;
        end
    end

    genvar p;
    generate
        for (p = 0; p < NPORTS; p++)
        begin : g_port
            // a write lands on every port enabled in the select register
            always_ff @(posedge sys_clk)
            begin
                if (rst)
                begin
                    thresh[p]   <= dlm_pkg::RST_THRESH;
                    cnt_en[p]   <= dlm_pkg::RST_CNT_EN;
                    wait_ign[p] <= dlm_pkg::RST_WAIT_IGN;
                    crc_dis[p]  <= dlm_pkg::RST_CRC_DIS;
                    enc_rsvd[p] <= dlm_pkg::RST_ENC_RSVD;
                    fv_min[p]   <= dlm_pkg::RST_FV_MIN;
                end
                else if (reg_wr && port_sel[p])
                begin
                    if (reg_addr == dlm_pkg::OFS_LINK_ERR_MON)
                    begin
                        thresh[p]   <= reg_wdata[dlm_pkg::THRESH_LSB +: dlm_pkg::THRESH_W];
                        cnt_en[p]   <= reg_wdata[dlm_pkg::CNT_EN_BIT];
                        wait_ign[p] <= reg_wdata[dlm_pkg::WAIT_IGN_BIT];
                    end
                    if (reg_addr == dlm_pkg::OFS_ENC_CRC_CTRL)
                    begin
                        crc_dis[p]  <= reg_wdata[dlm_pkg::CRC_DIS_BIT];
                        enc_rsvd[p] <= reg_wdata[6:0];
                    end
                    if (reg_addr == dlm_pkg::OFS_FRAME_VALID_MIN_TIME)
                    begin
                        fv_min[p] <= reg_wdata;
                    end
                end
            end

            dlm_err_mon u_err_mon
            (
                .sys_clk     (sys_clk),
                .rst         (rst),
                .pix_en      (pix_en[p]),
                .cdr_lock    (cdr_lock[p]),
                .err_parity  (err_parity[p]),
                .err_clock   (err_clock[p]),
                .err_ctrl    (err_ctrl[p]),
                .filter_wait (filter_wait[p]),
                .cnt_en      (cnt_en[p]),
                .ignore_wait (wait_ign[p]),
                .thresh      (thresh[p]),
                .locked      (mon_locked[p]),
                .err_count   (mon_count[p])
            );

            dlm_fs_gen u_fs_gen
            (
                .sys_clk     (sys_clk),
                .rst         (rst),
                .pix_en      (pix_en[p]),
                .raw_mode    (raw_mode[p]),
                .frame_valid (frame_valid[p]),
                .min_time    (fv_min[p]),
                .frame_start (fs_pulse[p])
            );

            // failed-crc packets are dropped only while checking is on
            always_ff @(posedge sys_clk)
            begin
                if (rst)
                begin
                    link_info[p] <= 8'h00;
                end
                else if (enc_pkt_valid[p] && (crc_dis[p] || enc_pkt_crc_ok[p]))
                begin
                    link_info[p] <= enc_pkt_info[p];
                end
            end

            // registered copies keep outputs straight from flops
            always_ff @(posedge sys_clk)
            begin
                if (rst)
                begin
                    link_locked[p] <= 1'b0;
                    frame_start[p] <= 1'b0;
                end
                else
                begin
                    link_locked[p] <= mon_locked[p];
                    frame_start[p] <= fs_pulse[p];
                end
            end
        end
    endgenerate

    // read port index from select bit 4; a single-port build always reads port 0
    assign rd_port = (NPORTS > 1) ? port_sel[dlm_pkg::PSEL_RD_BIT] : 1'b0;

    always_comb
    begin
        next_rdata = 8'h00;
        unique case (reg_addr)
            dlm_pkg::OFS_PORT_SEL:
            begin
                next_rdata = port_sel;
            end
            dlm_pkg::OFS_ENC_CAP:
            begin
                next_rdata[dlm_pkg::CAP_BIT] = crc_cap;
            end
            dlm_pkg::OFS_PORT_STATUS:
            begin
                next_rdata = {mon_count[rd_port], 3'h0, mon_locked[rd_port]};
            end
            dlm_pkg::OFS_LINK_ERR_MON:
            begin
                next_rdata = {2'h0, wait_ign[rd_port], cnt_en[rd_port], thresh[rd_port]};
            end
            dlm_pkg::OFS_ENC_CRC_CTRL:
            begin
                next_rdata = {crc_dis[rd_port], enc_rsvd[rd_port]};
            end
            dlm_pkg::OFS_RSVD_BB:
            begin
                next_rdata = dlm_pkg::RSVD_BB_VAL;
            end
            dlm_pkg::OFS_FRAME_VALID_MIN_TIME:
            begin
                next_rdata = fv_min[rd_port];
            end
            dlm_pkg::OFS_RSVD_BD:
            begin
                next_rdata = dlm_pkg::RSVD_BD_VAL;
            end
            dlm_pkg::OFS_GPIO_PD_DIS:
            begin
                next_rdata[NGPIO-1:0] = pd_dis;
            end
            dlm_pkg::OFS_RSVD_BF:
            begin
                next_rdata = dlm_pkg::RSVD_BF_VAL;
            end
            default:
            begin
                next_rdata = 8'h00;
            end
        endcase
    end

    // read data one cycle after the strobe
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            reg_rdata  <= 8'h00;
            reg_rvalid <= 1'b0;
        end
        else
        begin
            reg_rvalid <= reg_rd;
            if (reg_rd)
            begin
                reg_rdata <= next_rdata;
            end
        end
    end

endmodule

// file: dlm_pkg.sv
package dlm_pkg;

    // register offsets
    localparam logic [7:0] OFS_ENC_CAP      = 8'h4a;
    localparam logic [7:0] OFS_PORT_SEL     = 8'h4c;
    localparam logic [7:0] OFS_PORT_STATUS  = 8'h4d;
    localparam logic [7:0] OFS_LINK_ERR_MON = 8'hb9;
    localparam logic [7:0] OFS_ENC_CRC_CTRL = 8'hba;
    localparam logic [7:0] OFS_RSVD_BB      = 8'hbb;
    localparam logic [7:0] OFS_FRAME_VALID_MIN_TIME  = 8'hbc;
    localparam logic [7:0] OFS_RSVD_BD      = 8'hbd;
    localparam logic [7:0] OFS_GPIO_PD_DIS  = 8'hbe;
    localparam logic [7:0] OFS_RSVD_BF      = 8'hbf;

    // link error monitor fields
    localparam int THRESH_LSB     = 0;
    localparam int THRESH_W       = 4;
    localparam int CNT_EN_BIT     = 4;
    localparam int WAIT_IGN_BIT   = 5;
    localparam logic [3:0] RST_THRESH   = 4'h3;
    localparam logic       RST_CNT_EN   = 1'h1;
    localparam logic       RST_WAIT_IGN = 1'h1;

    // encoder crc control fields
    localparam int CRC_DIS_BIT    = 7;
    localparam int CAP_BIT        = 4;
    localparam logic       RST_CRC_DIS  = 1'h1;
    localparam logic [6:0] RST_ENC_RSVD = 7'h03;
    localparam logic       RST_CRC_CAP  = 1'h0;

    // frame valid minimum time
    localparam logic [7:0] RST_FV_MIN   = 8'h80;

    // reserved read values
    localparam logic [7:0] RSVD_BB_VAL  = 8'h74;
    localparam logic [7:0] RSVD_BD_VAL  = 8'h00;
    localparam logic [7:0] RSVD_BF_VAL  = 8'h00;

    // gpio pulldown
    localparam logic [6:0] RST_PD_DIS   = 7'h00;

    // port select fields: write enables in low bits, read port at bit 4
    localparam int PSEL_RD_BIT    = 4;
    localparam logic [7:0] RST_PORT_SEL = 8'h01;

    // lock tracking states
    typedef enum logic [1:0]
    {
        DLM_UNLOCKED = 2'b01,
        DLM_LOCKED   = 2'b10
    } dlm_lock_e;

endpackage

// file: dlm_err_mon.sv
`timescale 1ns/1ps
module dlm_err_mon
(
    input  wire logic       sys_clk,
    input  wire logic       rst,
    input  wire logic       pix_en,
    input  wire logic       cdr_lock,
    input  wire logic       err_parity,
    input  wire logic       err_clock,
    input  wire logic       err_ctrl,
    input  wire logic       filter_wait,
    input  wire logic       cnt_en,
    input  wire logic       ignore_wait,
    input  wire logic [3:0] thresh,
    output logic            locked,
    output logic [3:0]      err_count
);

    dlm_pkg::dlm_lock_e state;
    logic       link_err;
    logic [4:0] next_count;

    // parity, embedded clock and control faults all count
    assign link_err   = (err_parity | err_clock | err_ctrl)
                        & ~(ignore_wait & filter_wait);
    assign next_count = {1'b0, err_count} + 5'h01;

    // only advanced on pixel clock periods
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            state     <= dlm_pkg::DLM_UNLOCKED;
            err_count <= 4'h0;
        end
        else if (pix_en)
        begin
            unique case (state)
                dlm_pkg::DLM_UNLOCKED:
                begin
                    err_count <= 4'h0;
                    if (cdr_lock && !link_err)
                    begin
                        state <= dlm_pkg::DLM_LOCKED;
                    end
                end
                dlm_pkg::DLM_LOCKED:
                begin
                    if (!cdr_lock)
                    begin
                        state     <= dlm_pkg::DLM_UNLOCKED;
                        err_count <= 4'h0;
                    end
                    else if (link_err)
                    begin
                        if (!cnt_en || next_count >= {1'b0, thresh})
                        begin
                            state     <= dlm_pkg::DLM_UNLOCKED;
                            err_count <= 4'h0;
                        end
                        else
                        begin
                            err_count <= next_count[3:0];
                        end
                    end
                end
                default:
                begin
                    state <= dlm_pkg::DLM_UNLOCKED;
                end
            endcase
        end
    end

    assign locked = (state == dlm_pkg::DLM_LOCKED);

endmodule

// file: dlm_fs_gen.sv
`timescale 1ns/1ps
module dlm_fs_gen
(
    input  wire logic       sys_clk,
    input  wire logic       rst,
    input  wire logic       pix_en,
    input  wire logic       raw_mode,
    input  wire logic       frame_valid,
    input  wire logic [7:0] min_time,
    output logic            frame_start
);

    logic [7:0] fv_count;
    logic       fired;

    // one start per frame; count stops once it has fired
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            fv_count    <= 8'h00;
            fired       <= 1'b0;
            frame_start <= 1'b0;
        end
        else
        begin
            frame_start <= 1'b0;
            if (pix_en)
            begin
                if (!frame_valid || !raw_mode)
                begin
                    fv_count <= 8'h00;
                    fired    <= 1'b0;
                end
                else if (!fired)
                begin
                    if (fv_count >= min_time)
                    begin
                        frame_start <= 1'b1;
                        fired       <= 1'b1;
                    end
                    else
                    begin
                        fv_count <= fv_count + 8'h01;
                    end
                end
            end
        end
    end

endmodule

// file: dlm_chk.sv
`timescale 1ns/1ps
module dlm_chk
#(
    parameter int NPORTS = 2,
    parameter int NGPIO  = 7
)
(
    input wire logic                   sys_clk,
    input wire logic                   rst,
    input wire logic [7:0]             reg_addr,
    input wire logic                   reg_rd,
    input wire logic [7:0]             reg_rdata,
    input wire logic                   reg_rvalid,
    input wire logic [NPORTS-1:0]      pix_en,
    input wire logic [NPORTS-1:0]      cdr_lock,
    input wire logic [NPORTS-1:0]      raw_mode,
    input wire logic [NPORTS-1:0]      frame_valid,
    input wire logic [NPORTS-1:0]      enc_pkt_valid,
    input wire logic [NPORTS-1:0]      enc_pkt_crc_ok,
    input wire logic [NPORTS-1:0][7:0] enc_pkt_info,
    input wire logic [NPORTS-1:0]      link_locked,
    input wire logic [NPORTS-1:0]      frame_start,
    input wire logic [NPORTS-1:0][7:0] link_info,
    input wire logic [NGPIO-1:0]       gpio_out_en,
    input wire logic [NGPIO-1:0]       gpio_pulldown_en
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    sequence s_rd(logic [7:0] a);
        reg_rd && reg_addr == a;
    endsequence
    sequence s_cdr_loss;
        pix_en[0] && !cdr_lock[0];
    endsequence
    a_read_answer: assert property (1 |=> reg_rvalid == $past(reg_rd))
        else $error("read answer not one cycle after strobe");
    a_rsvd_fixed: assert property (s_rd(dlm_pkg::OFS_RSVD_BB) |=> reg_rdata == dlm_pkg::RSVD_BB_VAL)
        else $error("reserved byte value wrong");
    a_mon_top_zero: assert property (s_rd(dlm_pkg::OFS_LINK_ERR_MON) |=> !reg_rdata[7:6])
        else $error("monitor control top bits not zero");
    a_pd_top_zero: assert property (s_rd(dlm_pkg::OFS_GPIO_PD_DIS) |=> !reg_rdata[7])
        else $error("pulldown control top bit not zero");
    a_pd_off_out: assert property (1 |=> !(gpio_pulldown_en & $past(gpio_out_en)))
        else $error("pulldown on for an output pin");
    a_cdr_loss_drop: assert property (s_cdr_loss |=> ##1 !link_locked[0])
        else $error("lock kept after receiver lock loss");
    a_lock_needs_cdr: assert property ($rose(link_locked[0]) |->
        $past(pix_en[0], 2) && $past(cdr_lock[0], 2))
        else $error("lock rose without receiver lock");
    a_fs_cause: assert property (frame_start[0] |->
        $past(pix_en[0], 2) && $past(raw_mode[0], 2) && $past(frame_valid[0], 2)
        ##1 !frame_start[0])
        else $error("frame start without raw frame valid");
    a_info_accept: assert property (enc_pkt_valid[0] && enc_pkt_crc_ok[0] |=>
        link_info[0] == $past(enc_pkt_info[0]))
        else $error("good packet not taken");
    a_info_hold: assert property (!enc_pkt_valid[0] |=> $stable(link_info[0]))
        else $error("info changed without packet");
endmodule

bind dlm_regs_top dlm_chk #(.NPORTS(NPORTS), .NGPIO(NGPIO)) i_chk
(
    .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .pix_en(pix_en), .cdr_lock(cdr_lock),
    .raw_mode(raw_mode), .frame_valid(frame_valid), .enc_pkt_valid(enc_pkt_valid),
    .enc_pkt_crc_ok(enc_pkt_crc_ok), .enc_pkt_info(enc_pkt_info), .link_locked(link_locked),
    .frame_start(frame_start), .link_info(link_info), .gpio_out_en(gpio_out_en),
    .gpio_pulldown_en(gpio_pulldown_en)
);

// file: dlm_ser_model.sv
`timescale 1ns/1ps
module dlm_ser_model
(
    input  wire logic       sys_clk,
    input  wire logic       rst,
    input  wire logic       lock_in,
    input  wire logic       err_go,
    input  wire logic [1:0] err_sel,
    input  wire logic       fw,
    input  wire logic       raw,
    input  wire logic       fv,
    output logic [1:0]      pix_en,
    output logic [1:0]      cdr_lock,
    output logic [1:0]      err_parity,
    output logic [1:0]      err_clock,
    output logic [1:0]      err_ctrl,
    output logic [1:0]      filter_wait,
    output logic [1:0]      raw_mode,
    output logic [1:0]      frame_valid
);
    logic [1:0] phase;
    logic [2:0] pend;
    always_ff @(posedge sys_clk)
    begin
        phase <= rst ? 2'b00 : phase + 2'b01;
    end
    // an error waits for the next pixel period and lives for that one only
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            pend <= 3'b000;
        else if (err_go)
            pend <= 3'b001 << err_sel;
        else if (phase[0])
            pend <= 3'b000;
    end
    assign pix_en = {2{phase[0]}};
    // off-period fault lines carry junk: they must only be looked at on pix_en
    assign err_parity = phase[0] ? {2{pend[0]}} : {2{phase[1]}};
    assign err_clock = phase[0] ? {2{pend[1]}} : {2{phase[1]}};
    assign err_ctrl = phase[0] ? {2{pend[2]}} : {2{phase[1]}};
    assign cdr_lock = {2{lock_in}};
    assign filter_wait = {2{fw}};
    assign raw_mode = {2{raw}};
    assign frame_valid = {2{fv}};
endmodule

// file: tb.sv
`timescale 1ns/1ps
module tb;
    logic            sys_clk = 0;
    logic            rst = 1;
    logic [7:0]      reg_addr = 0;
    logic [7:0]      reg_wdata = 0;
    logic            reg_wr = 0;
    logic            reg_rd = 0;
    logic [7:0]      reg_rdata;
    logic            reg_rvalid;
    logic [1:0]      pix_en, cdr_lock, err_parity, err_clock, err_ctrl;
    logic [1:0]      filter_wait, raw_mode, frame_valid, link_locked, frame_start;
    logic [1:0]      enc_pkt_valid = 0;
    logic [1:0]      enc_pkt_crc_ok = 0;
    logic [1:0][7:0] enc_pkt_info = 0;
    logic [1:0][7:0] link_info;
    logic [6:0]      gpio_out_en = 0;
    logic [6:0]      gpio_pulldown_en;
    logic            lock_in = 0, err_go = 0, fw = 0, raw = 0, fv = 0;
    logic [1:0]      err_sel = 0;
    logic [31:0]     seed = 32'h46103d14;
    logic [7:0]      exp_q[$];
    logic [7:0]      r, n, cnt;
    int              err_count = 0;
    int              cmp_count = 0;
    logic [7:0]      ra[10] = '{8'hb9, 8'hba, 8'hbb, 8'hbc, 8'hbd, 8'hbe, 8'hbf, 8'h4a, 8'h4c, 8'h10};
    logic [7:0]      re[10] = '{8'h33, 8'h83, 8'h74, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00};

    dlm_regs_top i_dut
    (
        .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .pix_en(pix_en), .cdr_lock(cdr_lock), .err_parity(err_parity), .err_clock(err_clock),
        .err_ctrl(err_ctrl), .filter_wait(filter_wait), .raw_mode(raw_mode),
        .frame_valid(frame_valid), .enc_pkt_valid(enc_pkt_valid), .enc_pkt_crc_ok(enc_pkt_crc_ok),
        .enc_pkt_info(enc_pkt_info), .link_locked(link_locked), .frame_start(frame_start),
        .link_info(link_info), .gpio_out_en(gpio_out_en), .gpio_pulldown_en(gpio_pulldown_en)
    );
    dlm_ser_model i_ser
    (
        .sys_clk(sys_clk), .rst(rst), .lock_in(lock_in), .err_go(err_go), .err_sel(err_sel),
        .fw(fw), .raw(raw), .fv(fv), .pix_en(pix_en), .cdr_lock(cdr_lock),
        .err_parity(err_parity), .err_clock(err_clock), .err_ctrl(err_ctrl),
        .filter_wait(filter_wait), .raw_mode(raw_mode), .frame_valid(frame_valid)
    );

    initial
    begin
        forever #5 sys_clk = ~sys_clk;
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
        cmp_count++;
        if (seen !== exp)
        begin
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
            err_count++;
        end
    endtask

    task final_report;
        if (err_count == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // each access spans two cycles so a strobe is never lowered and raised in one step
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1;
        @(negedge sys_clk);
        reg_wr = 0;
        @(negedge sys_clk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        reg_addr = a;
        reg_rd = 1;
        exp_q.push_back(e);
        @(negedge sys_clk);
        reg_rd = 0;
        @(negedge sys_clk);
    endtask

    task automatic errs(input int k);
        repeat (k)
        begin
            err_go = 1;
            err_sel = (err_sel == 2'd2) ? 2'd0 : err_sel + 2'd1;
            @(negedge sys_clk);
            err_go = 0;
            repeat (2) @(negedge sys_clk);
        end
    endtask

    task automatic pkt(input logic ok, input logic [7:0] info);
        enc_pkt_valid = 2'b11;
        enc_pkt_crc_ok = {2{ok}};
        enc_pkt_info = {info, info};
        @(negedge sys_clk);
        enc_pkt_valid = 2'b00;
        @(negedge sys_clk);
    endtask

    always @(negedge sys_clk)
    begin
        if (reg_rvalid === 1'b1)
        begin
            if (exp_q.size() == 0)
                check(8'h01, 8'h00, "unexpected_rvalid");
            else
                check(reg_rdata, exp_q.pop_front(), "reg_rdata");
        end
    end

    initial
    begin
        #100us;
        err_count++;
        final_report;
    end

    initial
    begin
        repeat (20) @(negedge sys_clk);
        rst = 0;
        for (int i = 0; i < 10; i++)
            rd(ra[i], re[i]);
        wr(8'hb9, 8'hff);
        rd(8'hb9, 8'h3f);
        wr(8'hbb, 8'h00);
        rd(8'hbb, 8'h74);
        wr(8'hbe, 8'hff);
        rd(8'hbe, 8'h7f);
        wr(8'hb9, 8'h33);
        lock_in = 1;
        repeat (6) @(negedge sys_clk);
        check(link_locked, 2'b11, "lock_acquire");
        errs(2);
        check(link_locked, 2'b11, "below_thresh");
        errs(1);
        check(link_locked, 2'b00, "at_thresh");
        repeat (6) @(negedge sys_clk);
        errs(2);
        check(link_locked, 2'b11, "count_cleared");
        errs(1);
        repeat (6) @(negedge sys_clk);
        wr(8'hb9, 8'h23);
        errs(1);
        check(link_locked, 2'b10, "count_disabled");
        repeat (6) @(negedge sys_clk);
        wr(8'hb9, 8'h33);
        fw = 1;
        errs(3);
        check(link_locked, 2'b11, "wait_ignored");
        wr(8'hb9, 8'h13);
        errs(3);
        check(link_locked, 2'b10, "wait_counted");
        fw = 0;
        lock_in = 0;
        repeat (4) @(negedge sys_clk);
        check(link_locked, 2'b00, "cdr_loss");
        seed = xs(seed);
        n = {5'h00, seed[2:0]};
        wr(8'hbc, n);
        rd(8'hbc, n);
        raw = 1;
        fv = 1;
        cnt = 0;
        repeat (80)
        begin
            if (frame_start[0] === 1'b1)
                break;
            cnt = cnt + {7'h00, pix_en[0]};
            @(negedge sys_clk);
        end
        // start comes on the period after n periods of valid, so n + 1 periods are seen
        check(cnt, n + 8'h01, "frame_valid_min_time");
        fv = 0;
        raw = 0;
        @(negedge sys_clk);
        fv = 1;
        r = 0;
        repeat (40)
        begin
            @(negedge sys_clk);
            r = r | {7'h00, frame_start[0]};
        end
        check(r, 8'h00, "no_raw_no_start");
        fv = 0;
        pkt(0, 8'h5a);
        check(link_info[0], 8'h5a, "crc_off_info");
        wr(8'hba, 8'h03);
        rd(8'hba, 8'h03);
        pkt(0, 8'ha5);
        check(link_info[0], 8'h5a, "crc_bad_info");
        check(link_info[1], 8'ha5, "crc_off_port1");
        pkt(1, 8'hc3);
        check(link_info[0], 8'hc3, "crc_good_info");
        wr(8'h4a, 8'h10);
        rd(8'h4a, 8'h10);
        repeat (4)
        begin
            seed = xs(seed);
            wr(8'hbe, seed[7:0]);
            gpio_out_en = seed[14:8];
            repeat (2) @(negedge sys_clk);
            check({1'b0, gpio_pulldown_en}, {1'b0, ~gpio_out_en & ~seed[6:0]}, "pulldown");
        end
        wr(8'h4c, 8'h02);
        wr(8'hbc, 8'h11);
        rd(8'hbc, n);
        wr(8'h4c, 8'h12);
        rd(8'hbc, 8'h11);
        rd(8'h4c, 8'h12);
        repeat (4) @(negedge sys_clk);
        final_report;
    end
endmodule
